// File: bench/bp_ctrl_model.sv
// Peripheral controller model on the far side of the backplane
`timescale 1ns/1ns
module bp_ctrl_model (
  input  wire logic                           clk_i,     // Clock
  input  wire logic                           rst_i,     // Sync reset
  input  wire logic                           pio_en_i,  // Operation enable
  input  wire logic [7:0]                     grant_i,   // Grant
  input  wire logic                           strobe_i,  // Data strobe
  input  wire logic [15:0]                    word_i,    // Word to present
  input  wire logic                           bad_i,     // Corrupt parity
  input  wire logic [7:0]                     go_i,      // Slots that start a request
  input  wire logic [7:0]                     len_i,     // Block length
  input  wire logic [1:0]                     cls_i,     // Transfer class
  input  wire logic [15:0]                    base_i,    // Transfer address base
  output logic [15:0]                         data_o,    // Data lines
  output logic                                par_o,     // Odd parity
  output logic [7:0]                          req_o,     // Requests
  output logic [15:0]                         addr_o,    // Address lines
  output bp_io_pkg::direct_memory_class_t     class_o,   // Mode lines
  output logic                                last_o     // Block count exhausted
);
  logic       sel_ff; // Selected in the sample cycle
  logic [7:0] cnt_ff; // Words strobed so far
  logic [7:0] req_ff; // Pending requests
  logic [2:0] slot_w; // Granted slot
  always_comb begin
    slot_w = 3'h0;
    for (int s = 0; s < 8; s++) if (grant_i[s]) slot_w = 3'(s);
  end
  // Lines show the word only while enabled or selected, else move away from it
  assign data_o  = (pio_en_i || sel_ff) ? word_i : ~word_i;
  assign par_o   = ~^word_i ^ bad_i;
  assign req_o   = req_ff;
  assign addr_o  = |grant_i ? base_i + 16'(slot_w) : ~base_i;
  assign class_o = bp_io_pkg::direct_memory_class_t'(cls_i);
  assign last_o  = |grant_i && cnt_ff + 8'(strobe_i) == len_i - 8'h01;
  // Request held until granted, then dropped
  always_ff @(posedge clk_i) begin
    sel_ff <= pio_en_i;
    cnt_ff <= (|grant_i && !rst_i) ? cnt_ff + 8'(strobe_i) : 8'h00;
    req_ff <= rst_i ? 8'h00 : (req_ff | go_i) & ~grant_i;
  end
endmodule : bp_ctrl_model

// File: bench/bp_io_assertions.sv
// Port property checker for the backplane I/O block
`timescale 1ns/1ns
module bp_io_assertions #(
  parameter int NSLOT = 8,  // Backplane slots
  parameter int DW    = 16, // Data width
  parameter int AW    = 16  // Address width
) (
  input wire logic                                 clk_i,          // Clock
  input wire logic                                 rst_i,          // Sync reset
  input wire logic [AW-1:0]                        pc_i,           // Program counter in
  input wire logic                                 pio_done_o,     // Done pulse
  input wire logic                                 read_valid_o,   // Read valid pulse
  input wire logic [AW-1:0]                        pc_o,           // Program counter out
  input wire logic                                 pc_we_o,        // Counter write pulse
  input wire logic                                 parity_err_o,   // Parity error pulse
  input wire logic                                 pio_en_o,       // Operation enable
  input wire logic [1:0]                           pio_kind_o,     // Operation on lines
  input wire logic [9:0]                           bp_addr_o,      // Address lines out
  input wire logic [DW-1:0]                        bp_data_i,      // Data lines in
  input wire logic                                 bp_par_i,       // Data parity
  input wire logic                                 ctrl_ready_i,   // Ready answer
  input wire logic [NSLOT-1:0]                     dm_req_i,       // Requests
  input wire logic                                 dm_req_en_o,    // Request enable
  input wire logic [NSLOT-1:0]                     dm_grant_o,     // Grant
  input wire logic                                 dm_addr_tk_o,   // Address phase
  input wire bp_io_pkg::direct_memory_class_t      dm_cls_o,       // Decoded class
  input wire logic                                 dm_strobe_o,    // Data strobe
  input wire logic                                 end_of_range_o  // End of block
);
  import bp_io_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [NSLOT-1:0] low_w; // Lowest pending slot
  logic             spc_w; // Special controller addressed
  assign low_w = dm_req_i & (~dm_req_i + 1'b1);
  assign spc_w = bp_addr_o[5:0] == 6'h20;
  // --------------------
  // Programmed I/O
  // --------------------
  done_after_en_a: assert property (pio_en_o |-> ##2 pio_done_o)
    else $error("done not two cycles after enable");
  read_answer_a: assert property (pio_done_o && $past(pio_kind_o, 2) == 2'h0 |->
    read_valid_o == $past(ctrl_ready_i || spc_w)) else $error("read answer wrong");
  parity_check_a: assert property (pio_done_o |-> parity_err_o == (read_valid_o
    && !$past(spc_w) && !(^{$past(bp_data_i), $past(bp_par_i)}))) else $error("parity flag");
  pc_step_a: assert property (pc_we_o |-> pc_o == $past(pc_i) + 16'h0001
    && ($past(pio_kind_o) == 2'h2 || !$past(spc_w))) else $error("counter step wrong");
  cmd_silent_a: assert property (pio_done_o && $past(pio_kind_o) == 2'h3 |->
    !pc_we_o && !read_valid_o) else $error("command reported");
  // --------------------
  // Direct memory
  // --------------------
  grant_low_a: assert property ($rose(|dm_grant_o) |-> $past(dm_req_en_o)
    && dm_grant_o == $past(low_w)) else $error("grant not lowest request");
  grant_single_a: assert property ($onehot0(dm_grant_o)) else $error("grant not one-hot");
  phase_order_a: assert property ($rose(|dm_grant_o) |=> dm_addr_tk_o ##1 dm_strobe_o)
    else $error("phases out of order");
  burst_run_a: assert property (dm_strobe_o && !end_of_range_o &&
    dm_cls_o != direct_queue_transfer |=> dm_strobe_o) else $error("block not back to back");
  eor_place_a: assert property (end_of_range_o |-> dm_strobe_o &&
    dm_cls_o != direct_queue_transfer) else $error("end of range misplaced");
  cover property (read_valid_o && parity_err_o);
  cover property (end_of_range_o);
  cover property (pc_we_o);
endmodule : bp_io_assertions

bind bp_io bp_io_assertions #(.NSLOT(NSLOT), .DW(DW), .AW(AW)) u_bp_io_assertions (
  .clk_i, .rst_i, .pc_i, .pio_done_o, .read_valid_o, .pc_o, .pc_we_o, .parity_err_o,
  .pio_en_o, .pio_kind_o, .bp_addr_o, .bp_data_i, .bp_par_i, .ctrl_ready_i, .dm_req_i,
  .dm_req_en_o, .dm_grant_o, .dm_addr_tk_o, .dm_cls_o, .dm_strobe_o, .end_of_range_o);

// File: bench/bp_io_bench.sv
// Self-checking bench for the backplane I/O block
`timescale 1ns/1ns
`include "bp_io_cfg.svh"
module bp_io_bench;
  import bp_io_pkg::*;
  logic clk_i, rst_i, pio_start_i, bad, dm_allow_i, intr_busy_i, bp_par_i, ctrl_ready_i;
  logic pio_done_o, read_valid_o, pc_we_o, cc_we_o, parity_err_o, pio_en_o, bp_data_oe_o;
  logic dm_last_i, dm_req_en_o, dm_addr_tk_o, dm_strobe_o, end_of_range_o, dm_late_o;
  pio_op_t pio_op_i;
  arch_mode_t mode_i;
  direct_memory_class_t dm_class_i, dm_cls_o;
  logic [5:0] ctrl_addr_i;
  logic [3:0] func_i;
  logic [15:0] acc_i, pc_i, word, base, read_data_o, pc_o, bp_data_o, bp_addr_i, bp_data_i;
  logic [15:0] dm_addr_o;
  logic [9:0] bp_addr_o;
  logic [7:0] go, len, dm_req_i, dm_grant_o;
  logic [1:0] cc_o, pio_kind_o, cls;
  int n_errors = 0, tests_run = 0, seed = 32'h77b8_7b96;
  bp_io u_bp_io (.clk_i, .rst_i, .pio_start_i, .pio_op_i, .mode_i, .ctrl_addr_i, .func_i,
    .acc_i, .pc_i, .pio_done_o, .read_data_o, .read_valid_o, .pc_o, .pc_we_o, .cc_o, .cc_we_o,
    .parity_err_o, .pio_en_o, .pio_kind_o, .bp_addr_o, .bp_data_o, .bp_data_oe_o, .bp_addr_i,
    .bp_data_i, .bp_par_i, .ctrl_ready_i, .dm_allow_i, .intr_busy_i, .dm_req_i, .dm_class_i,
    .dm_last_i, .dm_req_en_o, .dm_grant_o, .dm_addr_tk_o, .dm_addr_o, .dm_cls_o, .dm_strobe_o,
    .end_of_range_o, .dm_late_o);
  bp_ctrl_model u_bp_ctrl_model (.clk_i, .rst_i, .pio_en_i(pio_en_o), .grant_i(dm_grant_o),
    .strobe_i(dm_strobe_o), .word_i(word), .bad_i(bad), .go_i(go), .len_i(len), .cls_i(cls),
    .base_i(base), .data_o(bp_data_i), .par_o(bp_par_i), .req_o(dm_req_i), .addr_o(bp_addr_i),
    .class_o(dm_class_i), .last_o(dm_last_i));
  // Clock at 50 ns
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // Advance n edges, then drive just after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask : cyc
  // A wait that ran out of its bound ends the run
  task automatic lim(input int k, input int m);
    if (k >= m) begin
      n_errors++;
      end_sim();
    end
  endtask : lim
  // Expected success of one programmed operation
  function automatic logic exp_ok(input logic [1:0] op, input logic [5:0] a, input logic r);
    return (op < 2'h2) ? (r || a == 6'h20) : (op == 2'h2 && r);
  endfunction : exp_ok
  // One programmed operation with its expected report
  task automatic pio(input logic [1:0] op, md, input logic [5:0] a, input logic r, b);
    logic ok;
    int k;
    pio_op_i = pio_op_t'(op);
    mode_i = arch_mode_t'(md);
    ctrl_addr_i = a;
    func_i = 4'($random(seed));
    ctrl_ready_i = r;
    bad = b;
    word = 16'($random(seed));
    acc_i = ~word;
    pc_i = word ^ 16'h5a5a;
    ok = exp_ok(op, a, r);
    pio_start_i = 1'b1;
    cyc(1);
    pio_start_i = 1'b0;
    chk(pio_en_o, 1'b1);
    chk(pio_kind_o, op);
    chk(bp_addr_o, {func_i, a});
    cyc(1);
    chk(bp_data_oe_o, op == 2'h1 && ok);
    if (op == 2'h1 && ok) chk(bp_data_o, acc_i);
    for (k = 0; k < 8 && pio_done_o !== 1'b1; k++) cyc(1);
    lim(k, 8);
    chk(read_valid_o, op == 2'h0 && ok);
    if (op == 2'h0 && ok) chk(read_data_o, word);
    chk(parity_err_o, op == 2'h0 && ok && a != 6'h20 && b);
    chk(pc_we_o, md != 2'h2 && ok && (a != 6'h20 || op == 2'h2));
    if (pc_we_o === 1'b1) chk(pc_o, pc_i + 16'h0001);
    chk(cc_we_o, md == 2'h2);
    if (md == 2'h2) chk(cc_o, ok ? 2'h1 : 2'h2);
    cyc(1);
  endtask : pio
  // Slots 1 and 3 ask together; both blocks must complete in order
  task automatic dm(input logic [1:0] c, input logic [7:0] n);
    int k, s, e;
    cls = c;
    len = n;
    base = 16'($random(seed)) & 16'hfff0;
    go = 8'h0a;
    cyc(1);
    go = 8'h00;
    for (int j = 0; j < 2; j++) begin
      s = 0;
      e = 0;
      for (k = 0; k < 200 && |dm_grant_o !== 1'b1; k++) cyc(1);
      lim(k, 200);
      chk(dm_grant_o, j ? 8'h08 : 8'h02);
      for (k = 0; k < 8 && dm_addr_tk_o !== 1'b1; k++) cyc(1);
      lim(k, 8);
      chk(dm_addr_o, base + (j ? 16'h0003 : 16'h0001));
      chk(dm_cls_o, c);
      for (k = 0; k < 300 && (|dm_grant_o || dm_strobe_o) === 1'b1; k++) begin
        s += int'(dm_strobe_o);
        e += int'(end_of_range_o);
        cyc(1);
      end
      lim(k, 300);
      chk(16'(s), c == 2'h3 ? 16'h0001 : 16'(n));
      chk(16'(e), c != 2'h3);
    end
  endtask : dm
  // Main sequence
  initial begin
    int k;
    {rst_i, pio_start_i, bad, dm_allow_i, intr_busy_i, ctrl_ready_i} = 6'h21;
    {pio_op_i, mode_i, ctrl_addr_i, func_i, acc_i, pc_i, word} = '0;
    {go, len, cls, base} = '0;
    cyc(6);
    rst_i = 1'b0;
    // Every operation in modes s, r and v, special and ordinary address, ready both ways
    for (int i = 0; i < 48; i++)
      pio(2'(i % 4), 2'((i / 4) % 3), (i / 12) % 2 ? 6'h20 : 6'h05, 1'(i / 24), 1'b1);
    for (int i = 0; i < 60; i++) pio(2'($random(seed)), 2'($random(seed)) % 2'h3,
      ($random(seed) & 3) == 0 ? 6'h20 : 6'($random(seed)),
      1'($random(seed)), 1'($random(seed)));
    // Requests are held off while enable conditions fail
    intr_busy_i = 1'b1;
    dm_allow_i = 1'b1;
    go = 8'h02;
    cyc(1);
    go = 8'h00;
    for (k = 0; k < 200 && dm_late_o !== 1'b1; k++) cyc(1);
    lim(k, 200);
    chk(16'(k), 16'(`WAIT_LIMIT_CYC));
    chk(dm_grant_o, 8'h00);
    {intr_busy_i, dm_allow_i} = 2'h0;
    cyc(20);
    chk(dm_grant_o, 8'h00);
    dm_allow_i = 1'b1;
    for (int c = 0; c < 4; c++) dm(2'(c), 8'(3 + c));
    end_sim();
  end
endmodule : bp_io_bench

// File: logic/bp_io.sv
// Backplane programmed I/O sequencer and direct-memory request arbiter
// Notes on behaviour
// - Same I/O actions in every mode
// - Read not ready, not '20: ends, no data
// - Ready or '20 read captures data lines
// - Ready or '20 write drives accumulator out
// - Non-virtual read/write success adds one, except '20
// - Address '20 reads ignore parity
// - Other reads check parity, flag errors
// - Virtual mode sets success/failure codes
// - Ready test ends early if not ready; code still runs it through p_addr and p_eval like any other operation
// - Non-virtual ready test adds one only if ready
// - Command issued, no ready check, no step; virtual mode codes failure
// - Four direct transfer classes supported
// - Request, address, data phases in order
// - Serve requests only while enable asserted
// - Lowest slot number wins
// - Class decoded to interpret address
// - Strobe data; end of range at block end
// - No service during interrupts or phantom code
// - Highest priority wait under 7 us; code does not bound it, only flags an overdue wait on dm_late_o
// - Rest of block moves back to back
`timescale 1ns/1ns
`include "bp_io_cfg.svh"

module bp_io #(
  parameter int NSLOT   = 8,   // Backplane slots
  parameter int DW      = 16,  // Data line width
  parameter int AW      = 16   // Address line width
) (
  input  wire logic                              clk_i,         // 20 MHz clock
  input  wire logic                              rst_i,         // Sync reset, high
  // Programmed I/O request from the instruction unit
  input  wire logic                              pio_start_i,   // Start operation pulse
  input  wire bp_io_pkg::pio_op_t                pio_op_i,      // Operation kind
  input  wire bp_io_pkg::arch_mode_t             mode_i,        // Architectural mode
  input  wire logic [5:0]                        ctrl_addr_i,   // Controller address
  input  wire logic [3:0]                        func_i,        // Function code
  input  wire logic [DW-1:0]                     acc_i,         // Accumulator contents
  input  wire logic [AW-1:0]                     pc_i,          // Current program counter
  output logic                                   pio_done_o,    // Operation done pulse
  output logic [DW-1:0]                          read_data_o,   // Captured read value
  output logic                                   read_valid_o,  // Read data valid pulse
  output logic [AW-1:0]                          pc_o,          // Updated program counter
  output logic                                   pc_we_o,       // Program counter write pulse
  output logic [1:0]                             cc_o,          // Condition codes
  output logic                                   cc_we_o,       // Condition code write pulse
  output logic                                   parity_err_o,  // Data-line parity error pulse
  // Backplane
  output logic                                   pio_en_o,      // Operation enable on lines
  output logic [1:0]                             pio_kind_o,    // Operation on lines
  output logic [9:0]                             bp_addr_o,     // backplane_address_lines out
  output logic [DW-1:0]                          bp_data_o,     // backplane_data_lines out
  output logic                                   bp_data_oe_o,  // Data lines driven
  input  wire logic [AW-1:0]                     bp_addr_i,     // backplane_address_lines in
  input  wire logic [DW-1:0]                     bp_data_i,     // backplane_data_lines in
  input  wire logic                              bp_par_i,      // Data parity (odd)
  input  wire logic                              ctrl_ready_i,  // Controller answers ready
  // Direct memory
  input  wire logic                              dm_allow_i,    // Pause point reached
  input  wire logic                              intr_busy_i,   // Interrupt/phantom code
  input  wire logic [NSLOT-1:0]                  dm_req_i,      // Requests, slot 0 highest
  input  wire bp_io_pkg::direct_memory_class_t   dm_class_i,    // Mode lines
  input  wire logic                              dm_last_i,     // Block count exhausted
  output logic                                   dm_req_en_o,   // Request enable
  output logic [NSLOT-1:0]                       dm_grant_o,    // One-hot grant
  output logic                                   dm_addr_tk_o,  // Address phase strobe
  output logic [AW-1:0]                          dm_addr_o,     // Captured transfer address
  output bp_io_pkg::direct_memory_class_t        dm_cls_o,      // Decoded class
  output logic                                   dm_strobe_o,   // Data phase strobe
  output logic                                   end_of_range_o,// End of block
  output logic                                   dm_late_o      // Service overdue flag
);
  import bp_io_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  localparam int WCW = $clog2(`WAIT_LIMIT_CYC + 1);

  // Fixed priority with no rotation: a busy low slot can hold off the
  // higher slots for as long as it keeps asking
  // Lowest-numbered pending slot, one-hot
  function automatic logic [NSLOT-1:0] pick_low(input logic [NSLOT-1:0] r);
    logic [NSLOT-1:0] g;
    g = '0;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (r[i]) begin
        g = '0;
        g[i] = 1'b1;
      end
    end
    return g;
  endfunction : pick_low

  // Block classes run to their count and close with end of range;
  // the queue class moves one word per request and never closes a range
  function automatic logic is_block(input direct_memory_class_t c);
    return c != direct_queue_transfer;
  endfunction : is_block

  // ----------------------------------------------------------------
  // Programmed I/O sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {p_idle, p_addr, p_eval} pio_st_t;

  pio_st_t      pst_ff;      // Sequencer state
  pio_op_t      op_ff;       // Latched operation
  arch_mode_t   md_ff;       // Latched mode
  logic [5:0]   ca_ff;       // Latched controller address
  logic [AW-1:0] pc_ff;      // Latched program counter
  logic         special;     // Address '20

  // Address '20 answers reads and writes and is exempt from their counter step
  assign special = (ca_ff == `SPECIAL_CTRL_ADDR);

  // Latch request and step the sequence; same actions in all modes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pst_ff <= p_idle;
      op_ff  <= read_from_controller;
      md_ff  <= mode_s;
      ca_ff  <= 6'h00;
      pc_ff  <= '0;
    end else begin
      unique case (pst_ff)
        p_idle: begin
          // Starts that arrive while busy are dropped
          if (pio_start_i) begin
            pst_ff <= p_addr;
            op_ff  <= pio_op_i;
            md_ff  <= mode_i;
            ca_ff  <= ctrl_addr_i;
            pc_ff  <= pc_i;
          end
        end
        p_addr: pst_ff <= p_eval;
        p_eval: pst_ff <= p_idle;
        default: pst_ff <= p_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Backplane drive
  // ----------------------------------------------------------------
  // Drive operation onto the address lines during the address cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pio_en_o     <= 1'b0;
      pio_kind_o   <= 2'h0;
      bp_addr_o    <= 10'h000;
      bp_data_o    <= '0;
      bp_data_oe_o <= 1'b0;
    end else begin
      pio_en_o     <= (pst_ff == p_idle) && pio_start_i;
      pio_kind_o   <= pio_op_i;
      bp_addr_o    <= {func_i, ctrl_addr_i};
      // Accumulator out only for a ready write or address '20
      bp_data_oe_o <= (pst_ff == p_addr) && (op_ff == write_to_controller)
                      && (ctrl_ready_i || special);
      bp_data_o    <= acc_i;
    end
  end

  // ----------------------------------------------------------------
  // Outcome decode and reporting
  // ----------------------------------------------------------------
  // Success decode and reporting per mode
  logic ok;      // Operation succeeded
  logic xfer;    // Read or write performed
  always_comb begin
    xfer = (op_ff != controller_ready_test) && (op_ff != controller_command)
           && (ctrl_ready_i || special);
    unique case (op_ff)
      read_from_controller, write_to_controller: ok = ctrl_ready_i || special;
      controller_ready_test: ok = ctrl_ready_i;
      // Commands never report success, whatever the controller does
      controller_command:    ok = 1'b0;
    endcase
  end

  // Report one cycle after the sample: codes in virtual mode, counter step otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pio_done_o   <= 1'b0;
      read_valid_o <= 1'b0;
      read_data_o  <= '0;
      pc_o         <= '0;
      pc_we_o      <= 1'b0;
      // Codes rest at failure until a virtual-mode report
      cc_o         <= `CC_FAILURE;
      cc_we_o      <= 1'b0;
      parity_err_o <= 1'b0;
    end else begin
      pio_done_o   <= 1'b0;
      read_valid_o <= 1'b0;
      pc_we_o      <= 1'b0;
      cc_we_o      <= 1'b0;
      parity_err_o <= 1'b0;
      if (pst_ff == p_eval) begin
        pio_done_o <= 1'b1;
        // Read capture and parity
        if (op_ff == read_from_controller && xfer) begin
          read_data_o  <= bp_data_i;
          read_valid_o <= 1'b1;
          parity_err_o <= !special && ~^{bp_data_i, bp_par_i};
        end
        if (md_ff == mode_v) begin
          cc_we_o <= 1'b1;
          cc_o    <= ok ? `CC_SUCCESS : `CC_FAILURE;
        end else if (op_ff == controller_ready_test) begin
          pc_we_o <= ok;
          pc_o    <= pc_ff + `PC_STEP;
        end else if (op_ff != controller_command) begin
          pc_we_o <= ok && !special;
          pc_o    <= pc_ff + `PC_STEP;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Direct memory arbitration and phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {d_req, d_addr, d_data} dm_st_t;

  dm_st_t          dst_ff;    // Phase
  logic [NSLOT-1:0] gnt;      // Combinational winner
  logic [WCW-1:0]  wait_ff;   // Cycles a request has waited
  logic            en;        // Request enable condition

  assign gnt = pick_low(dm_req_i);
  // Enable only between instructions, away from interrupt code, sequencer idle
  assign en  = dm_allow_i && !intr_busy_i && (pst_ff == p_idle);

  // Phase sequencer: request, address, data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dst_ff         <= d_req;
      dm_req_en_o    <= 1'b0;
      dm_grant_o     <= '0;
      dm_addr_tk_o   <= 1'b0;
      dm_addr_o      <= '0;
      dm_cls_o       <= direct_access;
      dm_strobe_o    <= 1'b0;
      end_of_range_o <= 1'b0;
    end else begin
      dm_addr_tk_o   <= 1'b0;
      dm_strobe_o    <= 1'b0;
      end_of_range_o <= 1'b0;
      unique case (dst_ff)
        d_req: begin
          dm_req_en_o <= en;
          // Grant only once the enable has already been shown to the slots
          if (dm_req_en_o && (|dm_req_i)) begin
            dm_grant_o  <= gnt;
            dm_req_en_o <= 1'b0;
            dst_ff      <= d_addr;
          end
        end
        d_addr: begin
          // Granted controller holds address and class on the lines now
          dm_addr_tk_o <= 1'b1;
          dm_addr_o    <= bp_addr_i;
          dm_cls_o     <= dm_class_i;
          dst_ff       <= d_data;
        end
        d_data: begin
          dm_strobe_o <= 1'b1;
          // Without a close the phase stays put, one word per cycle
          if (dm_last_i || !is_block(dm_cls_o)) begin
            // Queue moves one word per request; blocks end on count
            end_of_range_o <= dm_last_i && is_block(dm_cls_o);
            dm_grant_o     <= '0;
            dst_ff         <= d_req;
          end
        end
        default: dst_ff <= d_req;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Service wait monitor
  // ----------------------------------------------------------------
  // Watch how long the top request waits for the enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_ff   <= '0;
      dm_late_o <= 1'b0;
    end else if (dst_ff == d_req && (|dm_req_i)) begin
      // Saturate so the flag pulses once per wait
      if (wait_ff != WCW'(`WAIT_LIMIT_CYC))
        wait_ff <= wait_ff + 1'b1;
      dm_late_o <= (wait_ff == WCW'(`WAIT_LIMIT_CYC - 1));
    end else begin
      wait_ff   <= '0;
      dm_late_o <= 1'b0;
    end
  end

endmodule : bp_io

// File: logic/bp_io_cfg.svh
// Constants for the backplane I/O and direct-memory request logic
`ifndef BP_IO_CFG_SVH
`define BP_IO_CFG_SVH

`define SPECIAL_CTRL_ADDR   6'h20
`define PC_STEP             16'h0001
`define WAIT_LIMIT_NS       7000
`define CLK_PERIOD_NS       50
`define WAIT_LIMIT_CYC      ((`WAIT_LIMIT_NS) / (`CLK_PERIOD_NS))
`define CC_SUCCESS          2'h1
`define CC_FAILURE          2'h2

`endif

// File: logic/bp_io_pkg.sv
// Types for the backplane I/O and direct-memory request logic
package bp_io_pkg;

  // Programmed I/O operation kinds
  typedef enum logic [1:0] {
    read_from_controller,
    write_to_controller,
    controller_ready_test,
    controller_command
  } pio_op_t;

  // Architectural modes
  typedef enum logic [1:0] {
    mode_s,
    mode_r,
    mode_v,
    mode_rsvd
  } arch_mode_t;

  // Direct memory transfer classes
  typedef enum logic [1:0] {
    direct_access,
    direct_channel_transfer,
    direct_block_transfer,
    direct_queue_transfer
  } direct_memory_class_t;

endpackage : bp_io_pkg
